// [hdl/csc_pkg.sv]
/*
  Package for the counter status, command and interrupt summary block.
  Holds register offsets, bit positions, reset values, input mode codes
  and the packed structs that carry the counter core's events.
  Assumes one register clock shared with the counter core.
*/
package csc_pkg;

  // ==========================================================
  // Register map
  localparam int CSC_ADDR_W = 12;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_STATUS = 12'h130;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_CMD = 12'h134;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_ICR = 12'h140;
  localparam logic [31:0] CSC_RESET_WORD = 32'h0000_0000;

  // ==========================================================
  // Status register bit positions
  localparam int CSC_ST_CTRL_IRQ = 9;
  localparam int CSC_ST_MATCH_IRQ = 8;
  localparam int CSC_ST_SGL = 7;
  localparam int CSC_ST_OVERRUN = 6;
  localparam int CSC_ST_LATCHED = 5;
  localparam int CSC_ST_DIR = 4;
  localparam int CSC_ST_SIGN = 3;
  localparam int CSC_ST_MATCH = 2;
  localparam int CSC_ST_WRAP_UP = 1;
  localparam int CSC_ST_WRAP_DN = 0;
  localparam int CSC_ST_USED = 10;

  // Command register bit positions.
  localparam int CSC_CMD_LOAD = 1;
  localparam int CSC_CMD_CLEAR = 0;

  // Interrupt summary register bit positions.
  localparam int CSC_ICR_CTRL = 7;
  localparam int CSC_ICR_MATCH = 6;
  localparam int CSC_ICR_LINE = 5;
  localparam int CSC_ICR_DAC = 4;
  localparam int CSC_ICR_ADC_SEQ = 3;
  localparam int CSC_ICR_SETTLE = 2;
  localparam int CSC_ICR_CONV = 1;
  localparam int CSC_ICR_ENABLE = 0;
  localparam int CSC_ICR_USED = 8;

  // ==========================================================
  // Input mode codes of the counter core
  localparam logic [2:0] CSC_MODE_TIMER_UP = 3'h1;
  localparam logic [2:0] CSC_MODE_TIMER_DN = 3'h2;
  localparam logic [2:0] CSC_MODE_DIRECTION = 3'h3;

  // Events and levels from the counter core, all on the register clock.
  typedef struct packed {
    logic [31:0] count_value;
    logic [31:0] compare_value;
    logic [2:0] input_mode;
    logic count_pulse;
    logic count_up;
    logic counter_enabled;
    logic single_cycle_mode;
    logic ctrl_event;
    logic latch_ctrl_event;
    logic latch_mode_event;
    logic output_read;
    logic match_irq_enable;
  } csc_cnt_events_type;

  // Pending flags owned by other blocks, mirrored in the summary.
  typedef struct packed {
    logic line;
    logic dac_seq;
    logic adc_seq;
    logic settling;
    logic conversion;
  } csc_ext_irq_type;

  // Local bus request.
  typedef struct packed {
    logic req;
    logic we;
    logic [CSC_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } csc_bus_req_type;

endpackage

// [hdl/csc_sticky_flag.sv]
/*
  One sticky event flag: set by hardware, cleared by a clear request.
  Assumes set and clear are one-cycle levels on the register clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csc_sticky_flag
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);

  typedef struct packed {
    logic flag;
  } csc_flag_state_type;

  csc_flag_state_type st_q;
  csc_flag_state_type st_d;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb
  begin
    st_d = st_q;
    if (set)
      st_d.flag = 1'b1;
    else if (clr)
      st_d.flag = 1'b0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign flag_q = st_q.flag;

endmodule
`default_nettype wire

// [hdl/csc_sync3.sv]
/*
  Three-stage synchroniser for a pin level.
  The output follows once the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module csc_sync3
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level_q
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } csc_sync_state_type;

  csc_sync_state_type st_q;
  csc_sync_state_type st_d;

  // The first stage feeds only the second; agreement filters one glitch.
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
      st_d.level = st_q.s3;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level_q = st_q.level;

endmodule
`default_nettype wire

// [hdl/csc_counter_status.sv]
/*
  Counter status, command strobes and interrupt summary register.
  Assumes a local bus from the PCI bridge on the same clock as the
  counter core, one access per request cycle.
*/
// Function
// R1: Status bits 31:10 always read zero.
// R2: Status bit 9 shows pending control-mode interrupt; write one clears.
// R3: Status bit 8 shows match interrupt; clears with the match flag.
// R4: Status bit 7 is one in single-cycle mode with counter enabled.
// R5: Status bit 6 sets on latch event with unread latch; write one clears.
// R6: Status bit 5 sets on latch; cleared by output read or write one.
// R7: Status bit 4 gives direction: last count, or Y input in direction mode; timer modes fix it instead (up 1, down 0).
// R8: Status bit 3 is one after overflow, zero after underflow.
// R9: Status bit 2 sets on compare match; stays until write one.
// R10: Status bit 1 sets on wrap from all ones to zero.
// R11: Status bit 0 sets on wrap from zero to all ones.
// R12: Command bit 1 loads the counter from preload; self-clearing.
// R13: Command bit 0 resets the counter; bits 31:2 ignored.
// R14: Summary bits 7:5 mirror control, match and line interrupts.
// R15: Summary bits 4:1 mirror DAC, ADC sequencer, settling, conversion.
// R16: Summary mirrors are read-only; summary writes never clear them.
// R17: Summary bit 0 is master enable, reset zero, gates the request.
// R18: Summary bits 31:8 ignore writes and read zero.
// R19: Request equals enable AND any mirrored pending flag.
// R20: The counter is 32 bits; wraps are between all ones and zero.
`timescale 1ns/1ps
`default_nettype none
module csc_counter_status
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire csc_bus_req_type bus_req,
  output logic [31:0] bus_rdata_q,
  output logic bus_ack_q,
  input wire csc_cnt_events_type cnt_ev,
  input wire csc_ext_irq_type ext_irq,
  input wire logic y_pin,
  output logic load_from_preload_cmd_q,
  output logic clear_counter_cmd_q,
  output logic irq_q
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] prev_count;
    logic prev_valid;
    logic equal;
    logic dir;
    logic sign;
    logic single_cycle_active;
    logic global_irq_enable;
    logic load_cmd;
    logic clear_cmd;
    logic irq;
    logic [31:0] rdata;
    logic ack;
  } csc_state_type;

  csc_state_type st_q;
  csc_state_type st_d;

  logic y_level;
  logic control_mode_irq_pending;
  logic match_irq_pending;
  logic latch_overrun_flag;
  logic data_latched_flag;
  logic compare_hit_flag;
  logic wrap_up_flag;
  logic wrap_down_flag;

  logic wr_status;
  logic wr_cmd;
  logic wr_icr;
  logic rd_any;
  logic wrap_up_ev;
  logic wrap_dn_ev;
  logic match_ev;
  logic [31:0] status_word;
  logic [31:0] icr_word;
  logic [6:0] pending_vec;

  // ==========================================================
  // Bus decode
  // Every access is taken in its request cycle; unmapped reads give zero.
  assign wr_status = bus_req.req && bus_req.we &&
                     (bus_req.addr == CSC_OFS_STATUS);
  assign wr_cmd = bus_req.req && bus_req.we &&
                  (bus_req.addr == CSC_OFS_CMD);
  assign wr_icr = bus_req.req && bus_req.we &&
                  (bus_req.addr == CSC_OFS_ICR);
  assign rd_any = bus_req.req && !bus_req.we;

  // ==========================================================
  // Counter event detection
  // Wraps compare the previous and present 32-bit values.
  assign wrap_up_ev = st_q.prev_valid && (&st_q.prev_count) &&
                      (cnt_ev.count_value == 32'h0000_0000); // R10 R20
  assign wrap_dn_ev = st_q.prev_valid &&
                      (st_q.prev_count == 32'h0000_0000) &&
                      (&cnt_ev.count_value); // R11 R20
  // Only the first cycle of equality counts, so a parked counter
  // does not set the flag again right after software clears it.
  assign match_ev = (cnt_ev.count_value == cnt_ev.compare_value) &&
                    !st_q.equal; // R9

  // The Y input comes from a pin and is synchronised.
  csc_sync3 u_y_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(y_pin),
    .level_q(y_level)
  );

  // ==========================================================
  // Sticky flags
  // Control-mode interrupt, acknowledged by a one in bit 9.
  csc_sticky_flag u_ctrl_irq (
    .clk(clk),
    .rst_n(rst_n),
    .set(cnt_ev.ctrl_event),
    .clr(wr_status && bus_req.wdata[CSC_ST_CTRL_IRQ]), // R2
    .flag_q(control_mode_irq_pending)
  );

  // Match interrupt ignores a write to bit 8; it falls with the match flag on a write of one to bit 2.
  csc_sticky_flag u_match_irq (
    .clk(clk),
    .rst_n(rst_n),
    .set(match_ev && cnt_ev.match_irq_enable),
    .clr(wr_status && bus_req.wdata[CSC_ST_MATCH]), // R3
    .flag_q(match_irq_pending)
  );

  // Overrun: a latch event finds earlier data still unread.
  csc_sticky_flag u_overrun (
    .clk(clk),
    .rst_n(rst_n),
    .set(cnt_ev.latch_mode_event && data_latched_flag), // R5
    .clr(wr_status && bus_req.wdata[CSC_ST_OVERRUN]),
    .flag_q(latch_overrun_flag)
  );

  // Latched data flag, cleared by reading the output register too.
  csc_sticky_flag u_latched (
    .clk(clk),
    .rst_n(rst_n),
    .set(cnt_ev.latch_ctrl_event), // R6
    .clr(cnt_ev.output_read ||
         (wr_status && bus_req.wdata[CSC_ST_LATCHED])),
    .flag_q(data_latched_flag)
  );

  csc_sticky_flag u_match (
    .clk(clk),
    .rst_n(rst_n),
    .set(match_ev), // R9
    .clr(wr_status && bus_req.wdata[CSC_ST_MATCH]),
    .flag_q(compare_hit_flag)
  );

  csc_sticky_flag u_wrap_up (
    .clk(clk),
    .rst_n(rst_n),
    .set(wrap_up_ev), // R10
    .clr(wr_status && bus_req.wdata[CSC_ST_WRAP_UP]),
    .flag_q(wrap_up_flag)
  );

  csc_sticky_flag u_wrap_dn (
    .clk(clk),
    .rst_n(rst_n),
    .set(wrap_dn_ev), // R11
    .clr(wr_status && bus_req.wdata[CSC_ST_WRAP_DN]),
    .flag_q(wrap_down_flag)
  );

  // ==========================================================
  // Read words
  // Unused upper bits are built as zero, not stored.
  always_comb
  begin
    status_word = CSC_RESET_WORD; // R1
    status_word[CSC_ST_CTRL_IRQ] = control_mode_irq_pending;
    status_word[CSC_ST_MATCH_IRQ] = match_irq_pending;
    status_word[CSC_ST_SGL] = st_q.single_cycle_active;
    status_word[CSC_ST_OVERRUN] = latch_overrun_flag;
    status_word[CSC_ST_LATCHED] = data_latched_flag;
    status_word[CSC_ST_DIR] = st_q.dir;
    status_word[CSC_ST_SIGN] = st_q.sign;
    status_word[CSC_ST_MATCH] = compare_hit_flag;
    status_word[CSC_ST_WRAP_UP] = wrap_up_flag;
    status_word[CSC_ST_WRAP_DN] = wrap_down_flag;
  end

  // Mirrors are wired from their sources; nothing here can clear them.
  assign pending_vec = {control_mode_irq_pending, match_irq_pending,
                        ext_irq.line, ext_irq.dac_seq, ext_irq.adc_seq,
                        ext_irq.settling, ext_irq.conversion}; // R14 R15

  always_comb
  begin
    icr_word = CSC_RESET_WORD; // R18
    icr_word[CSC_ICR_CTRL:CSC_ICR_CONV] = pending_vec; // R16
    icr_word[CSC_ICR_ENABLE] = st_q.global_irq_enable;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.prev_count = cnt_ev.count_value;
    st_d.prev_valid = 1'b1;
    st_d.equal = (cnt_ev.count_value == cnt_ev.compare_value);
    // Single-cycle indication is a level of mode and enable.
    st_d.single_cycle_active = cnt_ev.single_cycle_mode &&
                               cnt_ev.counter_enabled; // R4
    // Direction: fixed in timer modes, Y in direction mode, else last.
    if (cnt_ev.input_mode == CSC_MODE_DIRECTION)
      st_d.dir = y_level; // R7
    else if (cnt_ev.input_mode == CSC_MODE_TIMER_UP)
      st_d.dir = 1'b1;
    else if (cnt_ev.input_mode == CSC_MODE_TIMER_DN)
      st_d.dir = 1'b0;
    else if (cnt_ev.count_pulse)
      st_d.dir = cnt_ev.count_up; // R7
    // Sign follows the last wrap; it is meaningless until the first.
    if (wrap_up_ev)
      st_d.sign = 1'b1; // R8
    else if (wrap_dn_ev)
      st_d.sign = 1'b0; // R8
    // Command strobes last one cycle; upper command bits are dropped.
    st_d.load_cmd = wr_cmd && bus_req.wdata[CSC_CMD_LOAD]; // R12
    st_d.clear_cmd = wr_cmd && bus_req.wdata[CSC_CMD_CLEAR]; // R13
    if (wr_icr)
      st_d.global_irq_enable = bus_req.wdata[CSC_ICR_ENABLE]; // R17
    // Request is the gated OR of all mirrors, held while any is pending.
    st_d.irq = st_q.global_irq_enable && (|pending_vec); // R17 R19
    // Read data answers one cycle after the request.
    st_d.ack = bus_req.req;
    st_d.rdata = CSC_RESET_WORD;
    if (rd_any)
    begin
      case (bus_req.addr)
        CSC_OFS_STATUS: st_d.rdata = status_word;
        CSC_OFS_ICR: st_d.rdata = icr_word;
        default: st_d.rdata = CSC_RESET_WORD;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign bus_rdata_q = st_q.rdata;
  assign bus_ack_q = st_q.ack;
  assign load_from_preload_cmd_q = st_q.load_cmd;
  assign clear_counter_cmd_q = st_q.clear_cmd;
  assign irq_q = st_q.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  status_reserved_a: assert property ( // R1
    rd_any && (bus_req.addr == CSC_OFS_STATUS)
    |=> bus_ack_q && (bus_rdata_q[31:CSC_ST_USED] == 22'h0)
  ) else $error("status reserved bits not zero");

  ctrl_ack_a: assert property ( // R2
    wr_status && bus_req.wdata[CSC_ST_CTRL_IRQ] && !cnt_ev.ctrl_event
    |=> !control_mode_irq_pending
  ) else $error("control irq not acknowledged");

  match_irq_a: assert property ( // R3
    !compare_hit_flag |-> !match_irq_pending
  ) else $error("match irq pending without match flag");

  single_cycle_a: assert property ( // R4
    cnt_ev.single_cycle_mode && cnt_ev.counter_enabled
    |=> status_word[CSC_ST_SGL]
  ) else $error("single cycle flag missing");

  overrun_set_a: assert property ( // R5
    cnt_ev.latch_mode_event && data_latched_flag |=> latch_overrun_flag
  ) else $error("overrun not flagged");

  latch_read_a: assert property ( // R6
    cnt_ev.output_read && !cnt_ev.latch_ctrl_event |=> !data_latched_flag
  ) else $error("latched flag survived output read");

  dir_follow_a: assert property ( // R7
    cnt_ev.input_mode == CSC_MODE_DIRECTION |=> st_q.dir == $past(y_level)
  ) else $error("direction does not follow Y");

  sign_wrap_a: assert property ( // R8
    wrap_up_ev |=> st_q.sign
  ) else $error("sign not set on overflow");

  wrap_up_a: assert property ( // R10
    wrap_up_ev |=> wrap_up_flag [*2] or (wrap_up_flag ##1 $past(wr_status))
  ) else $error("wrap up flag not held");

  wrap_dn_a: assert property ( // R11
    wrap_dn_ev |=> wrap_down_flag
  ) else $error("wrap down flag not set");

  load_pulse_a: assert property ( // R12
    wr_cmd && bus_req.wdata[CSC_CMD_LOAD] && !$past(wr_cmd)
    |=> load_from_preload_cmd_q ##1
        (!load_from_preload_cmd_q || $past(wr_cmd))
  ) else $error("load strobe not one cycle");

  icr_mirror_a: assert property ( // R14 R15 R16
    rd_any && (bus_req.addr == CSC_OFS_ICR)
    |=> bus_rdata_q[CSC_ICR_CTRL:CSC_ICR_CONV] == $past(pending_vec)
  ) else $error("summary mirror wrong");

  irq_gate_a: assert property ( // R17 R19
    !st_q.global_irq_enable |=> !irq_q
  ) else $error("request while master enable off");

  irq_hold_a: assert property ( // R19
    st_q.global_irq_enable && (|pending_vec) |=> irq_q
  ) else $error("request missing while pending");

  wrap_seen_c: cover property (wrap_up_ev ##[1:20] wrap_dn_ev);
  clear_cmd_c: cover property (clear_counter_cmd_q);
  irq_cycle_c: cover property (irq_q ##[1:50] !irq_q);
  overrun_c: cover property (latch_overrun_flag && data_latched_flag);

endmodule
`default_nettype wire

// [tb/csc_core_model.sv]
/*
  Behavioural counter core that stands behind the status block.
  Assumes the command pulses of the block and the step requests of the
  bench all arrive on the same rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module csc_core_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_cmd,
  input wire logic clear_cmd,
  input wire logic [31:0] preload,
  input wire logic step,
  input wire logic step_up,
  output logic [31:0] count_q,
  output logic pulse_q,
  output logic up_q
);
  // ==========================================================
  // Counter state
  // A command beats a step in the same cycle, as a reset would.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= 32'h0000_0000;
      pulse_q <= 1'b0;
      up_q <= 1'b0;
    end
    else
    begin
      pulse_q <= step;
      up_q <= step_up;
      if (clear_cmd)
        count_q <= 32'h0000_0000;
      else if (load_cmd)
        count_q <= preload;
      else if (step)
        count_q <= step_up ? count_q + 32'h1 : count_q - 32'h1;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
  Self-checking bench for the counter status block.
  Assumes the design package and the core model in csc_core_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import csc_pkg::*;

  logic clk;
  logic rst_n;
  csc_bus_req_type req;
  logic [31:0] rdata;
  logic ack;
  csc_cnt_events_type ev;
  csc_cnt_events_type ev_in;
  csc_ext_irq_type ext;
  logic y_pin;
  logic load_q;
  logic clear_q;
  logic irq;
  logic [31:0] preload;
  logic [31:0] cnt;
  logic step;
  logic step_up;
  logic pulse;
  logic up;
  logic [1:0] cmd_seen;
  int fail_count;
  int checks;

  // ==========================================================
  // Design and core model
  csc_counter_status csc_counter_status_i (.clk(clk), .rst_n(rst_n),
    .bus_req(req), .bus_rdata_q(rdata), .bus_ack_q(ack), .cnt_ev(ev_in),
    .ext_irq(ext), .y_pin(y_pin), .load_from_preload_cmd_q(load_q),
    .clear_counter_cmd_q(clear_q), .irq_q(irq));
  csc_core_model csc_core_model_i (.clk(clk), .rst_n(rst_n),
    .load_cmd(load_q), .clear_cmd(clear_q), .preload(preload),
    .step(step), .step_up(step_up), .count_q(cnt), .pulse_q(pulse),
    .up_q(up));

  // Count fields come from the model, the rest from the bench.
  always_comb
  begin
    ev_in = ev;
    ev_in.count_value = cnt;
    ev_in.count_pulse = pulse;
    ev_in.count_up = up;
  end

  // The clock runs at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  // One bus access; the answer is sampled half a cycle after the taking edge.
  task automatic acc(input logic we, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(negedge clk);
    req = '{req: 1'b1, we: we, addr: a, wdata: wd};
    @(negedge clk);
    req = '0;
    chk({31'h0, ack}, 32'h1);
    rd = rdata;
    cmd_seen = {load_q, clear_q};
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    acc(1'b1, a, wd, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    acc(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic step1(input logic dir_up);
    @(negedge clk);
    step = 1'b1;
    step_up = dir_up;
    @(negedge clk);
    step = 1'b0;
  endtask

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the tests need about 120 cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    ev = '0;
    ev.compare_value = 32'h0000_5555;
    ev.input_mode = 3'h4;
    ext = '0;
    y_pin = 1'b0;
    preload = 32'hffff_fffe;
    step = 1'b0;
    step_up = 1'b0;
    cmd_seen = 2'h0;
    fail_count = 0;
    checks = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(CSC_OFS_STATUS, 32'h0);
    rd_chk(CSC_OFS_ICR, 32'h0);
    rd_chk(CSC_OFS_CMD, 32'h0);
    rd_chk(12'h138, 32'h0);
    wr(CSC_OFS_CMD, 32'hffff_fffd);
    chk({30'h0, cmd_seen}, 32'h1);
    $display("Test reset and clear done");
    // Load just below all ones, then count up across the wrap.
    wr(CSC_OFS_CMD, 32'h0000_0002);
    chk({30'h0, cmd_seen}, 32'h2);
    step1(1'b1);
    step1(1'b1);
    rd_chk(CSC_OFS_STATUS, 32'h0000_001a);
    wr(CSC_OFS_STATUS, 32'h0000_0002);
    rd_chk(CSC_OFS_STATUS, 32'h0000_0018);
    step1(1'b0);
    rd_chk(CSC_OFS_STATUS, 32'h0000_0001);
    wr(CSC_OFS_STATUS, 32'h0000_0001);
    rd_chk(CSC_OFS_STATUS, 32'h0);
    $display("Test wraps done");
    // Match with its interrupt; bit 8 ignores a write of one.
    ev.match_irq_enable = 1'b1;
    ev.compare_value = 32'hffff_fffe;
    step1(1'b0);
    rd_chk(CSC_OFS_STATUS, 32'h0000_0104);
    wr(CSC_OFS_STATUS, 32'h0000_0100);
    rd_chk(CSC_OFS_STATUS, 32'h0000_0104);
    rd_chk(CSC_OFS_ICR, 32'h0000_0040);
    wr(CSC_OFS_ICR, 32'hffff_ffff);
    rd_chk(CSC_OFS_ICR, 32'h0000_0041);
    chk({31'h0, irq}, 32'h1);
    wr(CSC_OFS_STATUS, 32'h0000_0004);
    rd_chk(CSC_OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("Test match done");
    // Control event and latch, then a second latch event loses data.
    @(negedge clk);
    ev.ctrl_event = 1'b1;
    ev.latch_ctrl_event = 1'b1;
    @(negedge clk);
    ev.ctrl_event = 1'b0;
    ev.latch_ctrl_event = 1'b0;
    ev.latch_mode_event = 1'b1;
    @(negedge clk);
    ev.latch_mode_event = 1'b0;
    rd_chk(CSC_OFS_STATUS, 32'h0000_0260);
    rd_chk(CSC_OFS_ICR, 32'h0000_0081);
    chk({31'h0, irq}, 32'h1);
    wr(CSC_OFS_ICR, 32'h0000_0080);
    rd_chk(CSC_OFS_ICR, 32'h0000_0080);
    chk({31'h0, irq}, 32'h0);
    ev.output_read = 1'b1;
    @(negedge clk);
    ev.output_read = 1'b0;
    rd_chk(CSC_OFS_STATUS, 32'h0000_0240);
    wr(CSC_OFS_STATUS, 32'h0000_0240);
    rd_chk(CSC_OFS_STATUS, 32'h0);
    $display("Test control and latch done");
    // Each outside pending flag lands on its own summary bit.
    for (int i = 0; i < 5; i++)
    begin
      ext = 5'h10 >> i;
      rd_chk(CSC_OFS_ICR, 32'h0000_0020 >> i);
    end
    ext = 5'h1f;
    rd_chk(CSC_OFS_ICR, 32'h0000_003e);
    chk({31'h0, irq}, 32'h0);
    wr(CSC_OFS_ICR, 32'h0000_0001);
    rd_chk(CSC_OFS_ICR, 32'h0000_003f);
    chk({31'h0, irq}, 32'h1);
    ext = 5'h00;
    rd_chk(CSC_OFS_ICR, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    $display("Test summary done");
    // Single cycle flag and direction from the synchronised Y pin.
    ev.input_mode = CSC_MODE_DIRECTION;
    ev.single_cycle_mode = 1'b1;
    ev.counter_enabled = 1'b1;
    repeat (6) @(negedge clk);
    rd_chk(CSC_OFS_STATUS, 32'h0000_0080);
    y_pin = 1'b1;
    repeat (6) @(negedge clk);
    rd_chk(CSC_OFS_STATUS, 32'h0000_0090);
    ev.counter_enabled = 1'b0;
    rd_chk(CSC_OFS_STATUS, 32'h0000_0010);
    // Timer modes fix the direction whatever the Y pin shows.
    ev.input_mode = CSC_MODE_TIMER_DN;
    rd_chk(CSC_OFS_STATUS, 32'h0000_0000);
    ev.input_mode = CSC_MODE_TIMER_UP;
    rd_chk(CSC_OFS_STATUS, 32'h0000_0010);
    $display("Test single cycle and direction done");
    close_out();
  end
endmodule
`default_nettype wire
